// ---- verilog/ivd_top.sv ----
// interrupt request, daisy chain and vector return with an apb register file
`timescale 1ns/10ps
`default_nettype none
`include "ivd_defines.svh"
module ivd_top (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`IVD_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt sources, same clock
	input wire logic [`IVD_NSRC-1:0] src_event,
	input wire logic [2:0] port_a_status,
	input wire logic [2:0] port_b_status,
	// acknowledge pins
	input wire logic irq_ack_n,
	input wire logic data_strobe_n,
	input wire logic chain_enable_in,
	output logic chain_enable_out,
	output logic irq_req_n,
	output logic [7:0] data_o,
	output logic data_oe,
	// block interrupt
	output logic irq
);
	ivd_pkg::ivd_state_s st_r;
	ivd_pkg::ivd_state_s st_nxt;
	ivd_mem_if mif ();

	ivd_vec_mem #(
		.DEPTH(3)
	) u_mem (
		.clk(clk),
		.reset(reset),
		.port(mif.mem)
	);

	// chain, priority and status codes are written for five sources
	if (`IVD_NSRC != 5) begin : g_chk
		$error("ivd_top: five interrupt sources expected");
	end

	// first set bit, lowest index wins
	function automatic logic [3:0] first_src(input logic [`IVD_NSRC-1:0] req);
		logic [3:0] r;
		r = 4'h0;
		for (int i = `IVD_NSRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction

	function automatic logic [1:0] grp_of(input logic [2:0] src);
		logic [1:0] g;
		g = `IVD_GRP_CT;
		if (src == `IVD_SRC_A) begin
			g = `IVD_GRP_A;
		end else if (src == `IVD_SRC_B) begin
			g = `IVD_GRP_B;
		end
		return g;
	endfunction

	function automatic logic [1:0] ct_code(input logic [2:0] src);
		logic [1:0] c;
		c = `IVD_CT_ERR_CODE;
		if (src == `IVD_SRC_CT3) begin
			c = `IVD_CT3_CODE;
		end else if (src == `IVD_SRC_CT2) begin
			c = `IVD_CT2_CODE;
		end else if (src == `IVD_SRC_CT1) begin
			c = `IVD_CT1_CODE;
		end
		return c;
	endfunction

	// status replaces bits 3..1 for ports, bits 2..1 for timers
	function automatic logic [7:0] with_status(input logic [7:0] base, input logic [1:0] grp,
		input logic [2:0] pstat, input logic [1:0] code);
		logic [7:0] v;
		v = base;
		if (grp == `IVD_GRP_CT) begin
			v[2:1] = code;
		end else begin
			v[3:1] = pstat;
		end
		return v;
	endfunction

	function automatic logic [2:0] port_stat(input logic [1:0] grp, input logic [2:0] sa,
		input logic [2:0] sb);
		return (grp == `IVD_GRP_B) ? sb : sa;
	endfunction

	// internal chain: a source sees chain in only with no higher one blocking
	logic [`IVD_NSRC-1:0] iei_req;
	logic [`IVD_NSRC-1:0] iei_ack;
	logic [`IVD_NSRC-1:0] eligible;
	genvar gi;
	for (gi = 0; gi < `IVD_NSRC; gi++) begin : g_chain
		if (gi == 0) begin : g_head
			assign iei_req[gi] = st_r.cei_s2;
			assign iei_ack[gi] = st_r.cei_s2;
		end else begin : g_link
			assign iei_req[gi] = iei_req[gi-1] & ~st_r.irq_under_service_flag[gi-1];
			assign iei_ack[gi] = iei_ack[gi-1] & ~st_r.irq_under_service_flag[gi-1] & ~st_r.ip[gi-1];
		end
		assign eligible[gi] = st_r.ip[gi] & st_r.src_en[gi] & ~st_r.irq_under_service_flag[gi] & iei_ack[gi];
	end

	logic [3:0] win;
	logic [3:0] cur;
	logic [1:0] win_grp;
	logic [1:0] cur_grp;
	logic ack_active;
	logic ds_fall;
	logic ds_rise;
	logic [7:0] ack_vec;
	logic setup_ph;
	logic access_done;
	logic mapped;
	logic [`IVD_ADDR_W-1:0] addr_q;
	logic [1:0] rd_grp;
	logic [7:0] rd_vec;
	logic [31:0] rd_val;

	assign win = first_src(eligible);
	assign cur = first_src(st_r.ip & st_r.src_en);
	assign win_grp = grp_of(win[2:0]);
	assign cur_grp = grp_of(cur[2:0]);
	assign ack_active = ~st_r.ack_s2;
	// winner is chosen from settled chain, two edges after the pins
	assign ds_fall = st_r.ds_d & ~st_r.ds_s2;
	assign ds_rise = ~st_r.ds_d & st_r.ds_s2;
	assign ack_vec = st_r.vector_status_include[win_grp] ? with_status(mif.rdata_b, win_grp,
		port_stat(win_grp, port_a_status, port_b_status), ct_code(win[2:0])) : mif.rdata_b;

	assign setup_ph = psel & ~penable;
	assign access_done = psel & penable & st_r.rdy;
	assign addr_q = paddr;
	// unaligned or past the last register: error, write dropped, read zero
	assign mapped = addr_q[1:0] == 2'h0 && addr_q <= `IVD_OFF_IEN;

	// port a reads the addressed vector, port b the acknowledge winner
	always_comb begin
		rd_grp = `IVD_GRP_A;
		case (addr_q)
			`IVD_OFF_VEC_B: rd_grp = `IVD_GRP_B;
			`IVD_OFF_VEC_CT: rd_grp = `IVD_GRP_CT;
			`IVD_OFF_CURVEC: rd_grp = cur_grp;
			default: rd_grp = `IVD_GRP_A;
		endcase
	end

	assign mif.raddr_a = rd_grp;
	assign mif.raddr_b = win_grp;
	assign mif.we = access_done & pwrite & (addr_q == `IVD_OFF_VEC_A || addr_q == `IVD_OFF_VEC_B ||
		addr_q == `IVD_OFF_VEC_CT);
	assign mif.waddr = rd_grp;
	assign mif.wdata = pwdata[7:0];

	// vector seen by a register read
	logic [1:0] ct_pick;
	logic [3:0] ct_first;
	// base reads take the code of the highest pending timer, enabled or not
	assign ct_first = first_src(st_r.ip & 5'h15);
	assign ct_pick = ct_first[3] ? ct_code(ct_first[2:0]) : `IVD_CT_ERR_CODE;

	always_comb begin
		rd_vec = mif.rdata_a;
		if (addr_q == `IVD_OFF_CURVEC) begin
			if (!cur[3]) begin
				rd_vec = `IVD_NO_VEC;
			end else if (st_r.vector_status_include[cur_grp]) begin
				rd_vec = with_status(mif.rdata_a, cur_grp,
					port_stat(cur_grp, port_a_status, port_b_status), ct_code(cur[2:0]));
			end
		end else if (st_r.master_irq_enable) begin
			rd_vec = with_status(mif.rdata_a, rd_grp,
				port_stat(rd_grp, port_a_status, port_b_status), ct_pick);
		end
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		case (addr_q)
			`IVD_OFF_MCTRL: rd_val = {29'h0000_0000, st_r.ptr_hold, st_r.nv, st_r.master_irq_enable};
			`IVD_OFF_VEC_A, `IVD_OFF_VEC_B, `IVD_OFF_VEC_CT: rd_val = {24'h00_0000, rd_vec};
			`IVD_OFF_SRC_EN: rd_val = {27'h000_0000, st_r.src_en};
			`IVD_OFF_VIS: rd_val = {29'h0000_0000, st_r.vector_status_include};
			`IVD_OFF_PEND: rd_val = {27'h000_0000, st_r.ip};
			`IVD_OFF_IUS: rd_val = {27'h000_0000, st_r.irq_under_service_flag};
			`IVD_OFF_CURVEC: rd_val = {24'h00_0000, rd_vec};
			`IVD_OFF_ISTAT: rd_val = {29'h0000_0000, st_r.ist};
			`IVD_OFF_IEN: rd_val = {29'h0000_0000, st_r.ien};
			default: rd_val = 32'h0000_0000;
		endcase
	end

	always_comb begin
		logic [`IVD_NSRC-1:0] ip_clr;
		logic [`IVD_NSRC-1:0] ius_clr;
		logic [`IVD_NSRC-1:0] ius_set;
		logic [`IVD_NSRC-1:0] ip_set;
		logic [2:0] ist_clr;
		logic [2:0] ist_set;
		ip_clr = '0;
		ius_clr = '0;
		ius_set = '0;
		ip_set = '0;
		ist_clr = '0;
		ist_set = '0;
		st_nxt = st_r;

		// pin synchronisers
		// pins are asynchronous: two flops before any logic reads them
		// ds_d is a third stage used only to find strobe edges
		st_nxt.ack_s1 = irq_ack_n;
		st_nxt.ack_s2 = st_r.ack_s1;
		st_nxt.ds_s1 = data_strobe_n;
		st_nxt.ds_s2 = st_r.ds_s1;
		st_nxt.ds_d = st_r.ds_s2;
		st_nxt.cei_s1 = chain_enable_in;
		st_nxt.cei_s2 = st_r.cei_s1;

		// apb: one wait cycle, read data captured in the first access cycle
		// the registered store read port has settled by then
		if (psel && penable && !st_r.rdy) begin
			st_nxt.rdy = 1'b1;
			st_nxt.prdata = rd_val;
		end
		if (access_done) begin
			st_nxt.rdy = 1'b0;
		end
		if (setup_ph) begin
			st_nxt.prdata = 32'h0000_0000;
		end
		if (access_done && pwrite) begin
			case (addr_q)
				`IVD_OFF_MCTRL: begin
					st_nxt.master_irq_enable = pwdata[`IVD_MCTRL_MIE];
					st_nxt.nv = pwdata[`IVD_MCTRL_NV];
					st_nxt.ptr_hold = pwdata[`IVD_MCTRL_PTRHOLD];
				end
				`IVD_OFF_SRC_EN: st_nxt.src_en = pwdata[`IVD_NSRC-1:0];
				`IVD_OFF_VIS: st_nxt.vector_status_include = pwdata[2:0];
				`IVD_OFF_PEND: ip_clr = pwdata[`IVD_NSRC-1:0];
				`IVD_OFF_IUS: ius_clr = pwdata[`IVD_NSRC-1:0];
				`IVD_OFF_ICLR: ist_clr = pwdata[2:0];
				`IVD_OFF_IEN: st_nxt.ien = pwdata[2:0];
				default: ;
			endcase
		end

		// pending flags
		if (!st_r.ptr_hold) begin
			ip_set = src_event;
		end

		// acknowledge sequence
		// service is marked even when the vector is suppressed
		// no eligible source: only recorded, lines stay released
		case (st_r.ack)
			ivd_pkg::IVD_ACK_IDLE: begin
				if (ack_active && ds_fall) begin
					if (win[3]) begin
						ius_set[win[2:0]] = 1'b1;
						ist_set[`IVD_IST_ACK] = 1'b1;
						if (!st_r.nv) begin
							st_nxt.data_out = ack_vec;
							st_nxt.ack = ivd_pkg::IVD_ACK_DRIVE;
						end else begin
							ist_set[`IVD_IST_SUPP] = 1'b1;
						end
					end else begin
						ist_set[`IVD_IST_NOWIN] = 1'b1;
					end
				end
			end
			ivd_pkg::IVD_ACK_DRIVE: begin
				if (ds_rise) begin
					st_nxt.ack = ivd_pkg::IVD_ACK_IDLE;
				end
			end
			default: st_nxt.ack = ivd_pkg::IVD_ACK_IDLE;
		endcase

		// set wins over clear
		st_nxt.ip = (st_r.ip & ~ip_clr) | ip_set;
		st_nxt.irq_under_service_flag = (st_r.irq_under_service_flag & ~ius_clr) | ius_set;
		st_nxt.ist = (st_r.ist & ~ist_clr) | ist_set;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_r <= '0;
			// strobe stages reset to the idle high level, no false edge
			st_r.ack_s1 <= 1'b1;
			st_r.ack_s2 <= 1'b1;
			st_r.ds_s1 <= 1'b1;
			st_r.ds_s2 <= 1'b1;
			st_r.ds_d <= 1'b1;
			st_r.data_out <= `IVD_VEC_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs
	assign prdata = st_r.prdata;
	assign pready = psel & penable & st_r.rdy;
	assign pslverr = pready & ~mapped;
	// a source under service blocks every lower one, like an upstream chain
	assign irq_req_n = ~(st_r.master_irq_enable & |(st_r.ip & st_r.src_en & ~st_r.irq_under_service_flag & iei_req));
	assign chain_enable_out = ack_active ? (st_r.cei_s2 & ~|(st_r.ip | st_r.irq_under_service_flag)) : st_r.cei_s2;
	assign data_o = st_r.data_out;
	assign data_oe = st_r.ack == ivd_pkg::IVD_ACK_DRIVE;
	assign irq = |(st_r.ist & st_r.ien);
endmodule
`default_nettype wire

// ---- verilog/ivd_defines.svh ----
// offsets, field positions, reset values and codes of the interrupt vector block
`ifndef IVD_DEFINES_SVH
`define IVD_DEFINES_SVH

`define IVD_ADDR_W 12
`define IVD_OFF_MCTRL 12'h000
`define IVD_OFF_VEC_A 12'h004
`define IVD_OFF_VEC_B 12'h008
`define IVD_OFF_VEC_CT 12'h00C
`define IVD_OFF_SRC_EN 12'h010
`define IVD_OFF_VIS 12'h014
`define IVD_OFF_PEND 12'h018
`define IVD_OFF_IUS 12'h01C
`define IVD_OFF_CURVEC 12'h020
`define IVD_OFF_ISTAT 12'h024
`define IVD_OFF_ICLR 12'h028
`define IVD_OFF_IEN 12'h02C

`define IVD_MCTRL_MIE 0
`define IVD_MCTRL_NV 1
`define IVD_MCTRL_PTRHOLD 2

`define IVD_IST_ACK 0
`define IVD_IST_NOWIN 1
`define IVD_IST_SUPP 2

`define IVD_NSRC 5
`define IVD_SRC_CT3 3'h0
`define IVD_SRC_A 3'h1
`define IVD_SRC_CT2 3'h2
`define IVD_SRC_B 3'h3
`define IVD_SRC_CT1 3'h4

`define IVD_GRP_A 2'h0
`define IVD_GRP_B 2'h1
`define IVD_GRP_CT 2'h2

`define IVD_CT3_CODE 2'h0
`define IVD_CT2_CODE 2'h1
`define IVD_CT1_CODE 2'h2
`define IVD_CT_ERR_CODE 2'h3

`define IVD_VEC_RST 8'h00
`define IVD_NO_VEC 8'hFF

`endif

// ---- verilog/ivd_pkg.sv ----
// types of the interrupt vector block
package ivd_pkg;

	typedef enum logic {
		IVD_ACK_IDLE,
		IVD_ACK_DRIVE
	} ivd_ack_e;

	typedef struct packed {
		logic master_irq_enable;
		logic nv;
		logic ptr_hold;
		logic [4:0] src_en;
		logic [2:0] vector_status_include;
		logic [4:0] ip;
		logic [4:0] irq_under_service_flag;
		logic [2:0] ist;
		logic [2:0] ien;
		ivd_ack_e ack;
		logic ack_s1;
		logic ack_s2;
		logic ds_s1;
		logic ds_s2;
		logic ds_d;
		logic cei_s1;
		logic cei_s2;
		logic [7:0] data_out;
		logic [31:0] prdata;
		logic rdy;
	} ivd_state_s;

endpackage

// ---- verilog/ivd_mem_if.sv ----
// carrier between the block and its base vector store
`timescale 1ns/10ps
`default_nettype none
interface ivd_mem_if;
	logic we;
	logic [1:0] waddr;
	logic [7:0] wdata;
	logic [1:0] raddr_a;
	logic [7:0] rdata_a;
	logic [1:0] raddr_b;
	logic [7:0] rdata_b;

	modport ctrl (output we, output waddr, output wdata, output raddr_a, output raddr_b,
		input rdata_a, input rdata_b);
	modport mem (input we, input waddr, input wdata, input raddr_a, input raddr_b,
		output rdata_a, output rdata_b);
endinterface
`default_nettype wire

// ---- verilog/ivd_vec_mem.sv ----
// base vector store, one write port and two registered read ports
`timescale 1ns/10ps
`default_nettype none
module ivd_vec_mem #(
	parameter int DEPTH = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// access
	ivd_mem_if.mem port
);
	typedef struct packed {
		logic [DEPTH-1:0][7:0] word;
		logic [7:0] rdata_a;
		logic [7:0] rdata_b;
	} ivd_mem_s;

	ivd_mem_s st_r;
	ivd_mem_s st_nxt;

	if (DEPTH < 3 || DEPTH > 4) begin : g_chk
		$error("ivd_vec_mem: DEPTH must be 3 or 4");
	end

	always_comb begin
		st_nxt = st_r;
		if (port.we && 32'(port.waddr) < DEPTH) begin
			st_nxt.word[port.waddr] = port.wdata;
		end
		st_nxt.rdata_a = (32'(port.raddr_a) < DEPTH) ? st_r.word[port.raddr_a] : 8'h00;
		st_nxt.rdata_b = (32'(port.raddr_b) < DEPTH) ? st_r.word[port.raddr_b] : 8'h00;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign port.rdata_a = st_r.rdata_a;
	assign port.rdata_b = st_r.rdata_b;
endmodule
`default_nettype wire

// ---- verification/ivd_top_monitor.sv ----
// pin-level assertions of the interrupt vector block
`timescale 1ns/10ps
`default_nettype none
module ivd_top_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// acknowledge pins
	input wire logic irq_ack_n,
	input wire logic data_strobe_n,
	input wire logic chain_enable_in,
	input wire logic chain_enable_out,
	input wire logic irq_req_n,
	input wire logic data_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_strobe_up;
		data_strobe_n [*5];
	endsequence
	sequence s_req_ack;
		!irq_req_n ##1 $fell(irq_ack_n);
	endsequence
	property p_drive_cause;
		$rose(data_oe) |-> $past(irq_ack_n, 2) == 1'b0 && $past(data_strobe_n, 2) == 1'b0;
	endproperty
	a_drive_cause: assert property (p_drive_cause) else $error("vector driven without strobe");
	property p_release;
		s_strobe_up |-> !data_oe;
	endproperty
	a_release: assert property (p_release) else $error("data lines not released");
	property p_drive_hold;
		data_oe && !data_strobe_n |=> data_oe;
	endproperty
	a_drive_hold: assert property (p_drive_hold) else $error("vector dropped early");
	property p_req_chain;
		(!chain_enable_in) [*4] |-> irq_req_n;
	endproperty
	a_req_chain: assert property (p_req_chain) else $error("request with chain low");
	property p_chain_follow;
		(irq_ack_n && chain_enable_in) [*4] |-> chain_enable_out;
	endproperty
	a_chain_follow: assert property (p_chain_follow) else $error("chain out not following");
	property p_chain_low;
		(!chain_enable_in) [*4] |-> !chain_enable_out;
	endproperty
	a_chain_low: assert property (p_chain_low) else $error("chain out high with chain in low");
	property p_chain_pull;
		s_req_ack |-> ##[1:4] !chain_enable_out;
	endproperty
	a_chain_pull: assert property (p_chain_pull) else $error("chain not pulled low");
	property p_serviced;
		$rose(data_oe) |-> irq_req_n;
	endproperty
	a_serviced: assert property (p_serviced) else $error("request kept under service");
	property p_pready_wait;
		psel && penable && !pready |=> pready;
	endproperty
	a_pready_wait: assert property (p_pready_wait) else $error("pready late");
	property p_err_ready;
		pslverr |-> pready && psel && penable;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("pslverr outside access");
endmodule
bind ivd_top ivd_top_monitor ivd_top_monitor_i (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .irq_ack_n(irq_ack_n), .data_strobe_n(data_strobe_n),
	.chain_enable_in(chain_enable_in), .chain_enable_out(chain_enable_out), .irq_req_n(irq_req_n),
	.data_oe(data_oe));
`default_nettype wire

// ---- verification/ivd_host_model.sv ----
// host cpu and upstream chain neighbour on the acknowledge pins
`timescale 1ns/10ps
`default_nettype none
module ivd_host_model (
	// clock
	input wire logic clk,
	// pins toward the device
	output logic irq_ack_n,
	output logic data_strobe_n,
	output logic chain_enable_in,
	input wire logic [7:0] data_o,
	input wire logic data_oe
);
	logic [7:0] vec_seen;
	logic oe_seen;
	initial begin
		irq_ack_n = 1'b1;
		data_strobe_n = 1'b1;
		chain_enable_in = 1'b1;
		vec_seen = 8'h00;
		oe_seen = 1'b0;
	end
	// one acknowledge cycle, hold sets the strobe low time
	task automatic ack_cycle(input logic chain, input int hold);
		oe_seen = 1'b0;
		@(posedge clk);
		chain_enable_in <= chain;
		irq_ack_n <= 1'b0;
		repeat (5) @(posedge clk);
		data_strobe_n <= 1'b0;
		repeat (hold) begin
			@(posedge clk);
			if (data_oe === 1'b1) begin
				oe_seen = 1'b1;
				vec_seen = data_o;
			end
		end
		data_strobe_n <= 1'b1;
		repeat (6) @(posedge clk);
		irq_ack_n <= 1'b1;
		chain_enable_in <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// ---- verification/test_interrupt_vector_daisy_chain.sv ----
// self-checking bench of the interrupt vector block
`timescale 1ns/10ps
`default_nettype none
`include "ivd_defines.svh"
module test_interrupt_vector_daisy_chain;
	logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, irq_ack_n, data_strobe_n, chain_enable_in, chain_enable_out;
	logic irq_req_n, data_oe, irq;
	logic [4:0] src_event = 5'h0;
	logic [2:0] port_a_status = 3'h0, port_b_status = 3'h0, vector_status_include = 3'h0;
	logic [7:0] data_o;
	logic [7:0] base [3];
	int failures = 0, check_count = 0, s;
	integer seed = 32'hbb53b439;
	always #5 clk = ~clk;
	ivd_top ivd_top_i (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.src_event(src_event), .port_a_status(port_a_status), .port_b_status(port_b_status),
		.irq_ack_n(irq_ack_n), .data_strobe_n(data_strobe_n), .chain_enable_in(chain_enable_in),
		.chain_enable_out(chain_enable_out), .irq_req_n(irq_req_n), .data_o(data_o), .data_oe(data_oe),
		.irq(irq));
	ivd_host_model ivd_host_model_i (.clk(clk), .irq_ack_n(irq_ack_n), .data_strobe_n(data_strobe_n),
		.chain_enable_in(chain_enable_in), .data_o(data_o), .data_oe(data_oe));
	task automatic complete_run;
		if (failures == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			failures++;
			complete_run;
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	task automatic pulse(input logic [4:0] m);
		@(posedge clk);
		src_event <= m;
		@(posedge clk);
		src_event <= 5'h0;
		@(posedge clk);
	endtask
	// vector with cause status; src -1 means no timer pending
	function automatic logic [7:0] ins(input logic [7:0] b, input int g, input int src);
		logic [1:0] c;
		c = (src == 0) ? 2'h0 : (src == 2) ? 2'h1 : (src == 4) ? 2'h2 : 2'h3;
		if (g == 0)
			return {b[7:4], port_a_status, b[0]};
		if (g == 1)
			return {b[7:4], port_b_status, b[0]};
		return {b[7:3], c, b[0]};
	endfunction
	function automatic logic [7:0] ack_vec(input int src);
		int g;
		g = (src == 1) ? 0 : (src == 3) ? 1 : 2;
		return vector_status_include[g] ? ins(base[g], g, src) : base[g];
	endfunction
	initial begin
		#500000;
		failures++;
		complete_run;
	end
	initial begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		port_a_status <= 3'($random(seed));
		port_b_status <= 3'($random(seed));
		rdc(`IVD_OFF_VEC_A, 32'h0);
		rdc(`IVD_OFF_CURVEC, 32'hFF);
		apb(1'b0, 12'h030, 32'h0);
		check(err, 32'h1);
		check(rd, 32'h0);
		for (s = 0; s < 3; s++) begin
			base[s] = 8'($random(seed));
			apb(1'b1, `IVD_OFF_VEC_A + 12'(4 * s), 32'(base[s]));
		end
		for (s = 0; s < 3; s++)
			rdc(`IVD_OFF_VEC_A + 12'(4 * s), 32'(base[s]));
		apb(1'b1, `IVD_OFF_MCTRL, 32'h1);
		for (s = 0; s < 3; s++)
			rdc(`IVD_OFF_VEC_A + 12'(4 * s), 32'(ins(base[s], s, -1)));
		apb(1'b1, `IVD_OFF_SRC_EN, 32'h1F);
		apb(1'b1, `IVD_OFF_IEN, 32'h1);
		for (s = 0; s < 5; s++) begin
			vector_status_include = 3'($random(seed));
			apb(1'b1, `IVD_OFF_VIS, 32'(vector_status_include));
			pulse(5'(1 << s));
			check(irq_req_n, 32'h0);
			rdc(`IVD_OFF_CURVEC, 32'(ack_vec(s)));
			ivd_host_model_i.ack_cycle(1'b1, 6 + 2 * s);
			check(ivd_host_model_i.oe_seen, 32'h1);
			check(ivd_host_model_i.vec_seen, 32'(ack_vec(s)));
			rdc(`IVD_OFF_IUS, 32'(1 << s));
			check(irq, 32'h1);
			apb(1'b1, `IVD_OFF_ICLR, 32'h7);
			apb(1'b1, `IVD_OFF_PEND, 32'h1F);
			apb(1'b1, `IVD_OFF_IUS, 32'h1F);
			check(irq, 32'h0);
		end
		// chain held low upstream: no winner, masked status
		pulse(5'h02);
		ivd_host_model_i.ack_cycle(1'b0, 8);
		check(ivd_host_model_i.oe_seen, 32'h0);
		rdc(`IVD_OFF_IUS, 32'h0);
		check(irq, 32'h0);
		rdc(`IVD_OFF_ISTAT, 32'h2);
		apb(1'b1, `IVD_OFF_MCTRL, 32'h3);
		ivd_host_model_i.ack_cycle(1'b1, 8);
		check(ivd_host_model_i.oe_seen, 32'h0);
		rdc(`IVD_OFF_IUS, 32'h2);
		apb(1'b1, `IVD_OFF_PEND, 32'h1F);
		apb(1'b1, `IVD_OFF_IUS, 32'h1F);
		apb(1'b1, `IVD_OFF_MCTRL, 32'h5);
		pulse(5'h10);
		rdc(`IVD_OFF_PEND, 32'h0);
		apb(1'b1, `IVD_OFF_MCTRL, 32'h1);
		// two sources at once, then the lower one waits for service end
		pulse(5'h09);
		rdc(`IVD_OFF_CURVEC, 32'(ack_vec(0)));
		ivd_host_model_i.ack_cycle(1'b1, 8);
		check(ivd_host_model_i.vec_seen, 32'(ack_vec(0)));
		ivd_host_model_i.ack_cycle(1'b1, 8);
		check(ivd_host_model_i.oe_seen, 32'h0);
		apb(1'b1, `IVD_OFF_PEND, 32'h1);
		apb(1'b1, `IVD_OFF_IUS, 32'h1);
		ivd_host_model_i.ack_cycle(1'b1, 8);
		check(ivd_host_model_i.vec_seen, 32'(ack_vec(3)));
		complete_run;
	end
endmodule
`default_nettype wire
